// >>> rtl/can_mode_bit_timing_ctrl.v
// can controller mode, status, option and bit timing logic with APB registers
// assumes CAN_RX and all engine inputs are synchronous to REF_CLK;
// the protocol engine supplies error counters and frame events
//
// Summary of operation
// - bus-off flag set while transmit errors exceed 255, cleared in run mode once they no longer do
// - error-passive flag while error passive, clear when active or bus-off
// - self-receive set: own accepted message is stored
// - self-receive clear: every own transmitted message is discarded
// - no-retry set: failed message not resent, arbitration loss still retried
// - no-retry clear: failed message retransmitted until success
// - leave standby after one run of 11 recessive bits, else 128 runs
// - wake-up pulse bit set: dominant pulse on leaving standby, else none
// - setting run enable leaves standby after recessive synchronisation
// - clearing run enable enters standby after the transfer in progress
// - run bit reads 1 until standby actually entered, then 0
// - jump width field bits 7:6 allows field plus one quanta adjustment
// - prescaler field bits 5:0 gives quantum of field plus one clocks
// - segment-two field bits 6:4 gives field plus one quanta
// - segment-one field bits 3:0 gives field plus one quanta
// - bit time is (prescaler+1) times (seg1+seg2+3) clocks
// - prescaler and segment registers writable only in standby
// - page field selects diagnosis, buffers, filters or reserved window page
// - resynchronise only on recessive to dominant edges
//
// Local design decisions: the register offsets and the APB register port.
`include "can_mode_timing_map.vh"
`timescale 1ns/1ns
`default_nettype none

module can_mode_bit_timing_ctrl
(
    input wire REF_CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire CAN_RX,
    output wire CAN_TX,
    input wire TX_BIT,
    input wire [8:0] TX_ERR_COUNT,
    input wire [7:0] RX_ERR_COUNT,
    input wire XFER_BUSY,
    input wire RX_FRAME_DONE,
    input wire RX_ACCEPT_HIT,
    input wire RX_IS_OWN,
    input wire TX_FAILED,
    input wire ARB_LOST,
    output wire RX_STORE,
    output wire TX_RETRY,
    output wire TX_ABORT,
    output wire NODE_ON_BUS,
    output wire TQ_TICK,
    output wire BIT_START,
    output wire SAMPLE_POINT,
    output wire SAMPLED_BIT,
    output wire [2:0] PAGE_SEL,
    output wire [4:0] PAGE_ONE_HOT
);

    localparam ST_STANDBY = 3'd0;
    localparam ST_WAKE = 3'd1;
    localparam ST_SYNC = 3'd2;
    localparam ST_RUN = 3'd3;

    ////////////////////////////////////////////////////////////////////////
    // page decode: diagnosis, buffer 1..3, filters; reserved gives none
    function [4:0] page_decode;
        input [2:0] pg;
        begin
            case (pg)
                3'd0: page_decode = 5'b0_0001;
                3'd1: page_decode = 5'b0_0010;
                3'd2: page_decode = 5'b0_0100;
                3'd3: page_decode = 5'b0_1000;
                3'd4: page_decode = 5'b1_0000;
                default: page_decode = 5'b0_0000;
            endcase
        end
    endfunction

    reg [4:0] csr_r;
    reg [7:0] presc_r;
    reg [6:0] seg_r;
    reg [2:0] page_r;
    reg bus_off_r;
    reg err_passive_r;
    reg [2:0] mode_r;
    reg [2:0] mode_nxt;
    reg [31:0] prdata_r;
    reg pready_r;
    reg rx_store_r;
    reg retry_r;
    reg abort_r;
    reg can_tx_r;
    reg [5:0] tq_cnt_r;
    reg tq_tick_r;
    reg [4:0] q_r;
    reg [4:0] ext_r;
    reg resync_done_r;
    reg prev_rx_r;
    reg sampled_r;
    reg sample_pt_r;
    reg bit_start_r;
    reg [3:0] run_cnt_r;
    reg [7:0] seq_cnt_r;

    wire in_standby = (mode_r == ST_STANDBY);
    wire run_readback = csr_r[`BIT_RUN] | ~in_standby;
    wire setup_ph = PSEL & ~PENABLE;
    wire wr_take = PSEL & PENABLE & PWRITE & pready_r;
    wire [1:0] jw = presc_r[`JW_HI:`JW_LO];
    wire [5:0] presc = presc_r[`PRESC_HI:`PRESC_LO];
    wire [2:0] seg2 = seg_r[`SEG2_HI:`SEG2_LO];
    wire [3:0] seg1 = seg_r[`SEG1_HI:`SEG1_LO];
    wire [4:0] jw_q = {3'b000, jw} + 5'd1;
    wire [4:0] seg1_end = {1'b0, seg1} + 5'd1 + ext_r;
    wire [4:0] bit_last = seg1_end + {2'b00, seg2} + 5'd1;
    wire [7:0] seq_target = csr_r[`BIT_FAST_SYNC] ? `SYNC_SEQ_FAST : `SYNC_SEQ_STD;
    wire sync_met = (seq_cnt_r >= seq_target);

    ////////////////////////////////////////////////////////////////////////
    // apb: data latched in setup, ready in the first access cycle
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup_ph;
            if (setup_ph && !PWRITE)
            begin
                case (PADDR)
                    `OFS_CTRL_STATUS: prdata_r <= {25'd0, bus_off_r, err_passive_r, csr_r[4:1], run_readback};
                    `OFS_PRESC_JUMP: prdata_r <= {24'd0, presc_r};
                    `OFS_SEG_TIMING: prdata_r <= {25'd0, seg_r};
                    `OFS_PAGE_SEL: prdata_r <= {29'd0, page_r};
                    default: prdata_r <= 32'h0000_0000; // unmapped reads zero
                endcase
            end
        end
    end

    // register writes; reserved bits masked off regardless of what is written
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            csr_r <= 5'h00;
            presc_r <= `RST_PRESC_JUMP;
            seg_r <= 7'h23;
            page_r <= 3'h0;
        end
        else if (wr_take)
        begin
            case (PADDR)
                `OFS_CTRL_STATUS: csr_r <= PWDATA[4:0] & `CSR_WR_MASK;
                `OFS_PRESC_JUMP:
                begin
                    if (in_standby)
                        presc_r <= PWDATA[7:0];
                end
                `OFS_SEG_TIMING:
                begin
                    if (in_standby)
                        seg_r <= PWDATA[6:0];
                end
                `OFS_PAGE_SEL: page_r <= PWDATA[`PAGE_HI:`PAGE_LO];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault confinement status; the bus-off set outranks its clear, and bus-off outranks the error-passive set
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            bus_off_r <= 1'b0;
            err_passive_r <= 1'b0;
        end
        else
        begin
            if (TX_ERR_COUNT > `TEC_BUS_OFF_LIMIT)
                bus_off_r <= 1'b1;
            else if (mode_r == ST_RUN)
                bus_off_r <= 1'b0; // running with transmit errors at or below 255
            err_passive_r <= ~(TX_ERR_COUNT > `TEC_BUS_OFF_LIMIT) & ~bus_off_r
                & ((TX_ERR_COUNT > `ERR_PASSIVE_LIMIT) | ({1'b0, RX_ERR_COUNT} > `ERR_PASSIVE_LIMIT));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame options: store filter and retry decision, one-cycle pulses
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rx_store_r <= 1'b0;
            retry_r <= 1'b0;
            abort_r <= 1'b0;
        end
        else
        begin
            rx_store_r <= RX_FRAME_DONE & RX_ACCEPT_HIT
                & (~RX_IS_OWN | csr_r[`BIT_SELF_RX]);
            retry_r <= ARB_LOST | (TX_FAILED & ~csr_r[`BIT_NO_RETRY]);
            abort_r <= TX_FAILED & ~ARB_LOST & csr_r[`BIT_NO_RETRY];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time quantum divider: one tick every prescaler+1 clocks
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tq_cnt_r <= 6'd0;
            tq_tick_r <= 1'b0;
        end
        else if (tq_cnt_r >= presc)
        begin
            tq_cnt_r <= 6'd0;
            tq_tick_r <= 1'b1;
        end
        else
        begin
            tq_cnt_r <= tq_cnt_r + 6'd1;
            tq_tick_r <= 1'b0;
        end
    end

    // bit segment sequencer with edge resync; one resync per bit so a
    // noisy line cannot stretch a bit without bound
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            q_r <= 5'd0;
            ext_r <= 5'd0;
            resync_done_r <= 1'b0;
            prev_rx_r <= 1'b1;
            sampled_r <= 1'b1;
            sample_pt_r <= 1'b0;
            bit_start_r <= 1'b0;
        end
        else
        begin
            sample_pt_r <= 1'b0;
            bit_start_r <= 1'b0;
            if (tq_tick_r)
            begin
                prev_rx_r <= CAN_RX; // level held for one quantum
                if (q_r == seg1_end)
                begin
                    sampled_r <= CAN_RX;
                    sample_pt_r <= 1'b1;
                end
                if (prev_rx_r && !CAN_RX && !resync_done_r && q_r != 5'd0)
                begin
                    resync_done_r <= 1'b1;
                    if (q_r < seg1_end) // edge at the sample point counts as early
                    begin
                        // late edge: lengthen segment one
                        ext_r <= (q_r < jw_q) ? q_r : jw_q;
                        q_r <= q_r + 5'd1;
                    end
                    else if (bit_last - q_r < jw_q)
                    begin
                        // early edge within reach: start the next bit now
                        q_r <= 5'd1;
                        ext_r <= 5'd0;
                        bit_start_r <= 1'b1;
                    end
                    else
                        q_r <= q_r + jw_q + 5'd1; // shorten by jump width
                end
                else if (q_r >= bit_last)
                begin
                    q_r <= 5'd0;
                    ext_r <= 5'd0;
                    resync_done_r <= 1'b0;
                    bit_start_r <= 1'b1;
                end
                else
                    q_r <= q_r + 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recessive run counter used to rejoin the bus
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            run_cnt_r <= 4'd0;
            seq_cnt_r <= 8'd0;
        end
        else if (mode_r != ST_SYNC)
        begin
            run_cnt_r <= 4'd0;
            seq_cnt_r <= 8'd0;
        end
        else if (sample_pt_r)
        begin
            if (!sampled_r)
                run_cnt_r <= 4'd0; // dominant bit restarts the run
            else if (run_cnt_r == `RECESSIVE_RUN_LEN - 4'd1)
            begin
                run_cnt_r <= 4'd0;
                if (!sync_met)
                    seq_cnt_r <= seq_cnt_r + 8'd1;
            end
            else
                run_cnt_r <= run_cnt_r + 4'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always @*
    begin
        mode_nxt = mode_r;
        case (mode_r)
            ST_STANDBY:
            begin
                if (csr_r[`BIT_RUN])
                    mode_nxt = csr_r[`BIT_WAKE_PULSE] ? ST_WAKE : ST_SYNC;
            end
            ST_WAKE:
            begin
                if (!csr_r[`BIT_RUN])
                    mode_nxt = ST_STANDBY;
                else if (bit_start_r)
                    mode_nxt = ST_SYNC; // dominant pulse lasts until the next bit start
            end
            ST_SYNC:
            begin
                if (!csr_r[`BIT_RUN])
                    mode_nxt = ST_STANDBY;
                else if (sync_met)
                    mode_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (!csr_r[`BIT_RUN] && !XFER_BUSY)
                    mode_nxt = ST_STANDBY;
            end
            default: mode_nxt = ST_STANDBY;
        endcase
    end

    // mode register and bus drive; recessive unless waking or running
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_r <= ST_STANDBY;
            can_tx_r <= 1'b1;
        end
        else
        begin
            mode_r <= mode_nxt;
            if (mode_nxt == ST_WAKE)
                can_tx_r <= 1'b0;
            else if (mode_nxt == ST_RUN)
                can_tx_r <= TX_BIT;
            else
                can_tx_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = 1'b0;
    assign CAN_TX = can_tx_r;
    assign RX_STORE = rx_store_r;
    assign TX_RETRY = retry_r;
    assign TX_ABORT = abort_r;
    assign NODE_ON_BUS = (mode_r == ST_RUN);
    assign TQ_TICK = tq_tick_r;
    assign BIT_START = bit_start_r;
    assign SAMPLE_POINT = sample_pt_r;
    assign SAMPLED_BIT = sampled_r;
    assign PAGE_SEL = page_r;
    assign PAGE_ONE_HOT = page_decode(page_r);

endmodule // can_mode_bit_timing_ctrl

`default_nettype wire

// >>> rtl/can_mode_timing_map.vh
// constants for the can mode, status and bit timing block
// assumes an APB slave with one aligned 32-bit word per register
`ifndef CAN_MODE_TIMING_MAP_VH
`define CAN_MODE_TIMING_MAP_VH

// register byte offsets
`define OFS_CTRL_STATUS 8'h00
`define OFS_PRESC_JUMP 8'h04
`define OFS_SEG_TIMING 8'h08
`define OFS_PAGE_SEL 8'h0C

// reset values
`define RST_CTRL_STATUS 8'h00
`define RST_PRESC_JUMP 8'h00
`define RST_SEG_TIMING 8'h23
`define RST_PAGE_SEL 8'h00

// control/status field positions
`define BIT_BUS_OFF 6
`define BIT_ERR_PASSIVE 5
`define BIT_SELF_RX 4
`define BIT_NO_RETRY 3
`define BIT_FAST_SYNC 2
`define BIT_WAKE_PULSE 1
`define BIT_RUN 0
`define CSR_WR_MASK 5'h1F

// prescaler/jump and segment fields
`define JW_HI 7
`define JW_LO 6
`define PRESC_HI 5
`define PRESC_LO 0
`define SEG2_HI 6
`define SEG2_LO 4
`define SEG1_HI 3
`define SEG1_LO 0
`define PAGE_HI 2
`define PAGE_LO 0

// error counter thresholds
`define TEC_BUS_OFF_LIMIT 9'h0FF
`define ERR_PASSIVE_LIMIT 9'h07F

// resynchronisation counts
`define RECESSIVE_RUN_LEN 4'hB
`define SYNC_SEQ_STD 8'h80
`define SYNC_SEQ_FAST 8'h01

`endif

// >>> tb/can_bus_node.sv
// other nodes on the shared bus, seen as one wired-and line
// assumes the node under test drives recessive as 1
`timescale 1ns/1ns
`default_nettype none
module can_bus_node
(
    input wire logic node_tx,
    input wire logic other_dom,
    output logic bus_rx
);
    // dominant from any party wins; the idle bus is pulled recessive
    assign bus_rx = node_tx & ~other_dom;
endmodule // can_bus_node
`default_nettype wire

// >>> tb/can_mode_chk.sv
// port-level checker for the can mode and bit timing block
// assumes one clock domain and the reset low while active
`timescale 1ns/1ns
`default_nettype none
module can_mode_chk
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic RX_FRAME_DONE,
    input wire logic RX_ACCEPT_HIT,
    input wire logic RX_IS_OWN,
    input wire logic RX_STORE,
    input wire logic TX_FAILED,
    input wire logic ARB_LOST,
    input wire logic TX_RETRY,
    input wire logic TX_ABORT,
    input wire logic XFER_BUSY,
    input wire logic NODE_ON_BUS,
    input wire logic TX_BIT,
    input wire logic CAN_TX,
    input wire logic SAMPLE_POINT,
    input wire logic [2:0] PAGE_SEL,
    input wire logic [4:0] PAGE_ONE_HOT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////////////////////
    // zero wait state bus: one ready pulse per setup
    a_ready_follows: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    // frame storage and retry decisions
    a_store_foreign: assert property (RX_FRAME_DONE && RX_ACCEPT_HIT && !RX_IS_OWN |=> RX_STORE)
        else $error("accepted frame not stored");
    a_store_cause: assert property (!(RX_FRAME_DONE && RX_ACCEPT_HIT) |=> !RX_STORE)
        else $error("store without accepted frame");
    a_retry_arb: assert property (ARB_LOST |=> TX_RETRY && !TX_ABORT)
        else $error("lost arbitration not retried");
    a_abort_cause: assert property (TX_ABORT |-> $past(TX_FAILED) && !TX_RETRY)
        else $error("abort without failure");
    // standby only after the transfer has ended
    a_standby_wait: assert property ($fell(NODE_ON_BUS) |-> !$past(XFER_BUSY))
        else $error("left bus during transfer");
    a_tx_follow: assert property (NODE_ON_BUS |-> CAN_TX == $past(TX_BIT))
        else $error("transmit line not following engine");
    a_page_map: assert property (PAGE_ONE_HOT == (PAGE_SEL > 3'h4 ? 5'h00 : 5'h01 << PAGE_SEL))
        else $error("page decode wrong");
    a_sample_single: assert property (SAMPLE_POINT |=> !SAMPLE_POINT)
        else $error("bit sampled twice");
endmodule // can_mode_chk
bind can_mode_bit_timing_ctrl can_mode_chk u_chk (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PREADY, .RX_FRAME_DONE,
    .RX_ACCEPT_HIT, .RX_IS_OWN, .RX_STORE, .TX_FAILED, .ARB_LOST, .TX_RETRY, .TX_ABORT, .XFER_BUSY,
    .NODE_ON_BUS, .TX_BIT, .CAN_TX, .SAMPLE_POINT, .PAGE_SEL, .PAGE_ONE_HOT);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench: apb register tests, timing, options and mode changes
// assumes the design header on the include path
`include "can_mode_timing_map.vh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
logic REF_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, other_dom = 0;
logic TX_BIT = 1, XFER_BUSY = 0, RX_FRAME_DONE = 0, RX_ACCEPT_HIT = 0, RX_IS_OWN = 0, TX_FAILED = 0, ARB_LOST = 0;
logic [7:0] PADDR = 0, RX_ERR_COUNT = 0, q;
logic [8:0] TX_ERR_COUNT = 0;
logic [31:0] PWDATA = 0;
wire [31:0] PRDATA;
wire PREADY, PSLVERR, CAN_RX, CAN_TX, RX_STORE, TX_RETRY, TX_ABORT, NODE_ON_BUS;
wire TQ_TICK, BIT_START, SAMPLE_POINT, SAMPLED_BIT;
wire [2:0] PAGE_SEL;
wire [4:0] PAGE_ONE_HOT;
int failures = 0, total_checks = 0, cyc = 0, n, w, wake_cnt = 0;
logic [7:0] ofs[5] = '{`OFS_CTRL_STATUS, `OFS_PRESC_JUMP, `OFS_SEG_TIMING, `OFS_PAGE_SEL, 8'h10};
logic [7:0] rst[5] = '{8'h00, 8'h00, 8'h23, 8'h00, 8'h00};
logic [7:0] pj[2] = '{8'h02, 8'h41}, sg[2] = '{8'h35, 8'h23}, oc[3] = '{8'h08, 8'h08, 8'h10};
logic [4:0] ov[3] = '{5'h1E, 5'h19, 5'h1E};
logic [2:0] oe[3] = '{3'h1, 3'h6, 3'h6};
logic [8:0] tec[4] = '{9'h0FF, 9'h000, 9'h100, 9'h000};
logic [7:0] rec[4] = '{8'h00, 8'h82, 8'h00, 8'h00};
logic [1:0] st[4] = '{2'h1, 2'h1, 2'h2, 2'h0};
can_mode_bit_timing_ctrl dut (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .CAN_RX, .CAN_TX, .TX_BIT, .TX_ERR_COUNT, .RX_ERR_COUNT, .XFER_BUSY, .RX_FRAME_DONE,
    .RX_ACCEPT_HIT, .RX_IS_OWN, .TX_FAILED, .ARB_LOST, .RX_STORE, .TX_RETRY, .TX_ABORT, .NODE_ON_BUS,
    .TQ_TICK, .BIT_START, .SAMPLE_POINT, .SAMPLED_BIT, .PAGE_SEL, .PAGE_ONE_HOT);
can_bus_node bus (.node_tx(CAN_TX), .other_dom(other_dom), .bus_rx(CAN_RX));
////////////////////////////////////////////////////////////////
always #5 REF_CLK = ~REF_CLK;
// engine bit toggles, wake cycles counted, hang cut at a fixed ceiling
always @(posedge REF_CLK)
begin
    cyc <= cyc + 1;
    TX_BIT <= ~TX_BIT;
    if (!CAN_TX && !NODE_ON_BUS) wake_cnt <= wake_cnt + 1;
    if (cyc == 40000)
    begin
        failures++;
        close_out;
    end
end
task close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
        failures++;
        $display("FAIL %s expected %h seen %h", nm, e, s);
    end
endtask
// one transfer; an idle cycle after it keeps strobes from double assignment
task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d}; // reserved bits always written zero
    @(posedge REF_CLK);
    PENABLE <= 1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
    begin
        @(posedge REF_CLK);
    end
    q = PRDATA[7:0];
    chk("upper read bits and error", {PRDATA[31:8], PSLVERR}, 32'h0000_0000);
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge REF_CLK);
endtask
task wait_bus(input logic v, input int lim);
    n = 0;
    while (NODE_ON_BUS !== v && n < lim)
    begin
        @(posedge REF_CLK);
        n++;
    end
endtask
// cycles between two pulses of the tick (0) or bit start (1)
task gap(input logic sel, output int g);
    g = 0;
    while ((sel ? BIT_START : TQ_TICK) !== 1'b1 && g < 99)
    begin
        @(posedge REF_CLK);
        g++;
    end
    g = 0;
    do
    begin
        @(posedge REF_CLK);
        g++;
    end
    while ((sel ? BIT_START : TQ_TICK) !== 1'b1 && g < 99);
endtask
////////////////////////////////////////////////////////////////
initial
begin
    repeat (5) @(posedge REF_CLK);
    ARST_N <= 1;
    @(posedge REF_CLK);
    for (int i = 0; i < 5; i++)
    begin
        apb(0, ofs[i], 0);
        chk("reset value", q, rst[i]);
    end
    $display("reset test done");
    for (int p = 0; p < 8; p++)
    begin
        apb(1, `OFS_PAGE_SEL, p[7:0]);
        apb(0, `OFS_PAGE_SEL, 0);
        chk("page", {q, PAGE_ONE_HOT}, {p[7:0], p < 5 ? 5'h01 << p : 5'h00});
    end
    $display("page test done");
    // last table row stays: quantum 2 clocks, bit 16 clocks
    for (int i = 0; i < 2; i++)
    begin
        apb(1, `OFS_PRESC_JUMP, pj[i]);
        apb(1, `OFS_SEG_TIMING, sg[i]);
        apb(0, `OFS_SEG_TIMING, 0);
        chk("segments", q, sg[i]);
        gap(0, n);
        chk("quantum", n, pj[i][5:0] + 1);
        gap(1, n);
        chk("bit time", n, (pj[i][5:0] + 1) * (sg[i][6:4] + sg[i][3:0] + 3));
    end
    $display("timing test done");
    for (int i = 0; i < 3; i++)
    begin
        apb(1, `OFS_CTRL_STATUS, oc[i]);
        {RX_FRAME_DONE, RX_ACCEPT_HIT, RX_IS_OWN, TX_FAILED, ARB_LOST} <= ov[i];
        @(posedge REF_CLK);
        {RX_FRAME_DONE, RX_ACCEPT_HIT, RX_IS_OWN, TX_FAILED, ARB_LOST} <= 5'h00;
        @(posedge REF_CLK);
        chk("store retry abort", {RX_STORE, TX_RETRY, TX_ABORT}, oe[i]);
    end
    $display("option test done");
    // other node holds the bus dominant first, delaying the recessive runs
    apb(1, `OFS_CTRL_STATUS, 8'h07);
    other_dom <= 1;
    repeat (48) @(posedge REF_CLK);
    chk("dominant sample", SAMPLED_BIT, 1'b0);
    other_dom <= 0;
    wait_bus(1, 400);
    chk("fast join", n >= 160 && n <= 224, 1);
    chk("recessive sample", SAMPLED_BIT, 1'b1);
    // the pulse's own falling edge may resync and stretch its bit by the jump width
    chk("wake pulse", wake_cnt > 0 && wake_cnt <= 20, 1);
    apb(1, `OFS_PRESC_JUMP, 8'h3F);
    apb(0, `OFS_PRESC_JUMP, 0);
    chk("locked prescaler", q, 8'h41);
    for (int i = 0; i < 4; i++)
    begin
        TX_ERR_COUNT <= tec[i];
        RX_ERR_COUNT <= rec[i];
        repeat (3) @(posedge REF_CLK);
        apb(0, `OFS_CTRL_STATUS, 0);
        chk("error state", q[6:5], st[i]);
    end
    $display("run test done");
    XFER_BUSY <= 1;
    apb(1, `OFS_CTRL_STATUS, 8'h00);
    apb(0, `OFS_CTRL_STATUS, 0);
    chk("pending standby", {q[0], NODE_ON_BUS}, 2'h3);
    XFER_BUSY <= 0;
    wait_bus(0, 20);
    apb(0, `OFS_CTRL_STATUS, 0);
    chk("standby", {q[0], NODE_ON_BUS}, 2'h0);
    $display("standby test done");
    w = wake_cnt;
    apb(1, `OFS_CTRL_STATUS, 8'h01);
    wait_bus(1, 24000);
    chk("slow join", n >= 22500 && n <= 22600, 1);
    chk("no wake pulse", wake_cnt, w);
    $display("slow join test done");
    close_out;
end
endmodule // testbench
`default_nettype wire
